// ---- rtl/cpa_card_power_ctrl.sv ----
`default_nettype none

module cpa_card_power_ctrl #(
   parameter int SETTLE = cpa_pkg::SETTLE_CYC
) (
   input wire logic clock_i, // 250 MHz device clock
   input wire logic rst_i, // async reset, active high
   input wire logic hsel_i, // ahb slave select
   input wire logic [31:0] haddr_i, // ahb address
   input wire logic [1:0] htrans_i, // ahb transfer type
   input wire logic hwrite_i, // ahb write
   input wire logic [2:0] hsize_i, // ahb size, word only
   input wire logic [31:0] hwdata_i, // ahb write data
   input wire logic hready_i, // ahb bus ready
   output logic [31:0] hrdata_o, // ahb read data
   output logic hreadyout_o, // ahb slave ready
   output logic hresp_o, // ahb response, always okay
   input wire logic card_detect_in_1_i, // slot-1 presence contact
   input wire logic card_detect_in_2_i, // slot-2 presence, high = card
   input wire logic [5:0] supply_in_range_i, // a, b, slots 2..5 in range
   input wire logic [4:0] card_clk_i, // card clocks, slots 1..5
   input wire logic [4:0] card_io_line_i, // card i/o levels, slots 1..5
   output logic conv_a_run_o, // converter a enable
   output logic [1:0] conv_a_level_o, // converter a level code
   output logic conv_a_topology_sel_o, // 0 pump, 1 regulator
   output logic [1:0] conv_a_softstart_level_o, // start-up current step
   output logic conv_a_overcurrent_trim_o, // overcurrent shift
   output logic conv_b_run_o, // converter b enable
   output logic [1:0] conv_b_level_o, // converter b level code
   output logic conv_b_topology_sel_o, // 0 pump, 1 regulator
   output logic [1:0] conv_b_softstart_level_o, // start-up current step
   output logic conv_b_overcurrent_trim_o, // overcurrent shift
   output logic [3:0] slot_linear_reg_o, // regulator enables, slots 2..5
   output logic [7:0] slot_supply_sel_o, // regulator level codes
   output logic [4:0] card_reset_out_o // card reset, high = released
);

   localparam int N = cpa_pkg::NSLOT;
   localparam int LW = cpa_pkg::LVL_W;
   localparam int CW = cpa_pkg::CNT_W;

   // -------------------------------------------------------------------------
   // ahb-lite slave
   // -------------------------------------------------------------------------
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [31:0] rd_word;
   wire take = hsel_i & htrans_i[1] & hready_i;
   wire rd_take = take & ~hwrite_i;
   wire hi_zero = (haddr_i[31:8] == 24'h000000);
   wire [7:0] rd_addr = haddr_i[7:0];
   wire rd_status = rd_take & hi_zero & (rd_addr == cpa_pkg::OFF_STATUS);
   wire [31:0] wd = hwdata_i;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic bank_hit(input logic [7:0] a,
                                     input logic [2:0] bank);
      bank_hit = (a[7:5] == bank) && (a[1:0] == 2'h0) && (a[4:2] < 3'h5);
   endfunction

   wire wr_sc1 = wr_pend & hit(wr_addr, cpa_pkg::OFF_SC1);
   wire wr_cb = wr_pend & hit(wr_addr, cpa_pkg::OFF_CONVB);
   wire wr_sl = wr_pend & hit(wr_addr, cpa_pkg::OFF_SLOTS);
   wire wr_rst = wr_pend & hit(wr_addr, cpa_pkg::OFF_RST);
   wire wr_tim = wr_pend & bank_hit(wr_addr, cpa_pkg::BANK_TIMER);
   wire [2:0] wr_idx = wr_addr[4:2];

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata_o <= 32'h00000000;
         hreadyout_o <= 1'b0;
         hresp_o <= 1'b0;
      end else begin
         wr_pend <= take & hwrite_i & hi_zero;
         wr_addr <= rd_addr;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         if (rd_take) begin
            hrdata_o <= hi_zero ? rd_word : 32'h00000000;
         end
      end
   end

   // -------------------------------------------------------------------------
   // configuration registers
   // -------------------------------------------------------------------------
   logic [LW-1:0] a_lvl, b_lvl;
   logic [LW-1:0] slot_lvl [4];
   logic pol1, a_off, a_topo, a_trim, b_topo, b_trim, full2;
   logic [2:0] filt1;
   logic [1:0] a_ss, b_ss;
   logic [N-1:0] rst_ctrl, art_en;
   logic [CW-1:0] timer [N];
   logic present1, present2;
   logic [cpa_pkg::NSUP-1:0] good;
   logic [N-1:0] permit;
   wire conv_b_good = good[1];

   wire [LW-1:0] w_a_lvl = wd[cpa_pkg::SC1_LVL +: LW];
   wire w_a_off = wd[cpa_pkg::SC1_OFF];
   // R4 refuse start
   wire a_start_ok = present1 & ~w_a_off;
   // R6 auto stop
   wire a_run = (a_lvl != 2'h0);
   wire deact_a = a_run & (~present1 | a_off | (good[0] & ~supply_in_range_i[0]));

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         a_lvl <= 2'h0;
         {pol1, filt1, a_off, a_topo, a_ss, a_trim} <= 9'h000;
      end else if (wr_sc1) begin
         // R5 start converter a
         a_lvl <= (a_start_ok & ~deact_a) ? w_a_lvl : 2'h0;
         pol1 <= wd[cpa_pkg::SC1_POL];
         filt1 <= wd[cpa_pkg::SC1_FILT +: 3];
         a_off <= w_a_off;
         a_topo <= wd[cpa_pkg::SC1_TOPO];
         a_ss <= wd[cpa_pkg::SC1_SS +: 2];
         a_trim <= wd[cpa_pkg::SC1_TRIM];
      end else if (deact_a) begin
         // R6 auto stop
         a_lvl <= 2'h0;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         {b_lvl, b_topo, b_ss, b_trim} <= 6'h00;
      end else if (wr_cb) begin
         // R10 no presence check
         // R11 start converter b
         b_lvl <= wd[cpa_pkg::CB_LVL +: LW];
         b_topo <= wd[cpa_pkg::CB_TOPO];
         b_ss <= wd[cpa_pkg::CB_SS +: 2];
         b_trim <= wd[cpa_pkg::CB_TRIM];
      end
   end

   // R12 regulator start gate
   wire [3:0] sl_ok = {{3{conv_b_good}}, conv_b_good & present2};

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 4; i++) begin
            slot_lvl[i] <= 2'h0;
         end
         full2 <= 1'b0;
      end else if (wr_sl) begin
         for (int i = 0; i < 4; i++) begin
            // R16 level write starts slot
            if (sl_ok[i] || (wd[i*LW +: LW] == 2'h0)) begin
               slot_lvl[i] <= wd[i*LW +: LW];
            end
         end
         full2 <= wd[cpa_pkg::SL_FULL];
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rst_ctrl <= 5'h00;
         art_en <= 5'h00;
         for (int i = 0; i < N; i++) begin
            // R23 delay reset value
            timer[i] <= cpa_pkg::TIMER_RST;
         end
      end else begin
         if (wr_rst) begin
            rst_ctrl <= wd[cpa_pkg::RST_CTRL +: N];
            art_en <= wd[cpa_pkg::RST_ART +: N];
         end else if (deact_a) begin
            rst_ctrl[0] <= 1'b0;
         end
         if (wr_tim) begin
            timer[wr_idx] <= wd[CW-1:0];
         end
      end
   end

   // -------------------------------------------------------------------------
   // slot-1 presence filter
   // -------------------------------------------------------------------------
   logic [15:0] filt_cnt;
   logic ins_evt;
   // R1 polarity select
   wire raw1 = pol1 ? card_detect_in_1_i : ~card_detect_in_1_i;
   // R2 filter length
   wire [15:0] filt_len = 16'h0001 << (filt1 * cpa_pkg::FILT_SHIFT);
   wire filt_flip = (raw1 != present1) && (filt_cnt + 16'h0001 >= filt_len);

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         filt_cnt <= 16'h0000;
         present1 <= 1'b0;
         present2 <= 1'b0;
      end else begin
         present2 <= card_detect_in_2_i;
         if (raw1 == present1 || filt_flip) begin
            filt_cnt <= 16'h0000;
         end else begin
            filt_cnt <= filt_cnt + 16'h0001;
         end
         if (filt_flip) begin
            present1 <= raw1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // supply good detection
   // -------------------------------------------------------------------------
   wire [LW-1:0] lvl3 = full2 ? slot_lvl[0] : slot_lvl[1];
   wire [cpa_pkg::NSUP-1:0] running = {slot_lvl[3] != 2'h0,
      slot_lvl[2] != 2'h0, lvl3 != 2'h0, slot_lvl[0] != 2'h0,
      b_lvl != 2'h0, a_run};

   genvar k;
   generate
      for (k = 0; k < cpa_pkg::NSUP; k++) begin : g_good
         logic [15:0] settle_cnt;
         always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
               settle_cnt <= 16'h0000;
               good[k] <= 1'b0;
            end else if (!running[k] || !supply_in_range_i[k]) begin
               settle_cnt <= 16'h0000;
               good[k] <= 1'b0;
            end else if (settle_cnt >= 16'(SETTLE - 1)) begin
               // R5 good after settle
               // R11 good after settle
               good[k] <= 1'b1;
            end else begin
               settle_cnt <= settle_cnt + 16'h0001;
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------------
   // automatic reset timing, one engine per slot
   // -------------------------------------------------------------------------
   // R15 activation permission
   // R14 slot 3 disabled
   assign permit = {conv_b_good, conv_b_good, conv_b_good & ~full2,
                    present2, present1};
   wire [N-1:0] ctrl_eff = rst_ctrl & permit;
   logic [N-1:0] rel, ev_fail, ev_done, ev_tout;
   logic [CW-1:0] capt [N];

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_art
         cpa_pkg::cpa_art_e state;
         logic clk_q, io_q;
         logic [CW-1:0] cnt, cap;
         logic [7:0] ign;
         wire ck_rise = card_clk_i[g] & ~clk_q;
         // R25 answer start edge
         wire io_fall = ck_rise & io_q & ~card_io_line_i[g];
         // R20 ignore window
         wire ign_done = (ign >= cpa_pkg::IGNORE_CYC);
         wire answer = io_fall & ign_done;
         wire active = art_en[g] & ctrl_eff[g];
         assign capt[g] = cap;
         assign ev_fail[g] = (state == cpa_pkg::ART_WAIT) & ck_rise & answer;
         assign ev_done[g] = (state == cpa_pkg::ART_HELD) & ck_rise & answer;
         assign ev_tout[g] = (state == cpa_pkg::ART_HELD) & ck_rise &
                             ~answer & (cnt == cpa_pkg::CNT_MAX);

         always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
               clk_q <= 1'b0;
               io_q <= 1'b1;
            end else begin
               clk_q <= card_clk_i[g];
               if (ck_rise) begin
                  io_q <= card_io_line_i[g];
               end
            end
         end

         always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
               state <= cpa_pkg::ART_IDLE;
               cnt <= 16'h0000;
               ign <= 8'h00;
               rel[g] <= 1'b0;
               cap <= 16'h0000;
            end else if (!active) begin
               state <= cpa_pkg::ART_IDLE;
               cnt <= 16'h0000;
               ign <= 8'h00;
               rel[g] <= 1'b0;
            end else begin
               if (ck_rise && !ign_done) begin
                  ign <= ign + 8'h01;
               end
               case (state)
                  cpa_pkg::ART_IDLE: begin
                     // R19 counter start
                     state <= cpa_pkg::ART_WAIT;
                  end
                  cpa_pkg::ART_WAIT: begin
                     if (ck_rise && answer) begin
                        // R21 early answer fails
                        cap <= cnt;
                        state <= cpa_pkg::ART_END;
                     end else if (ck_rise && cnt == timer[g]) begin
                        // R19 release and clear
                        rel[g] <= 1'b1;
                        cnt <= 16'h0000;
                        state <= cpa_pkg::ART_HELD;
                     end else if (ck_rise) begin
                        cnt <= cnt + 16'h0001;
                     end
                  end
                  cpa_pkg::ART_HELD: begin
                     if (ck_rise && answer) begin
                        // R22 answer captured
                        cap <= cnt;
                        state <= cpa_pkg::ART_END;
                     end else if (ck_rise && cnt == cpa_pkg::CNT_MAX) begin
                        // R24 overflow ends wait
                        state <= cpa_pkg::ART_END;
                     end else if (ck_rise) begin
                        cnt <= cnt + 16'h0001;
                     end
                  end
                  cpa_pkg::ART_END: begin
                     state <= cpa_pkg::ART_END;
                  end
                  default: begin
                     state <= cpa_pkg::ART_IDLE;
                  end
               endcase
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------------
   // sticky status flags, set wins over read-clear
   // -------------------------------------------------------------------------
   logic [N-1:0] tout_flag, fail_flag, done_flag;
   wire clr = rd_status;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ins_evt <= 1'b0;
         tout_flag <= 5'h00;
         fail_flag <= 5'h00;
         done_flag <= 5'h00;
      end else begin
         // R3 insertion event
         ins_evt <= (ins_evt & ~clr) | filt_flip;
         // R24 timeout flag
         tout_flag <= (tout_flag & {N{~clr}}) | ev_tout;
         fail_flag <= (fail_flag & {N{~clr}}) | ev_fail;
         done_flag <= (done_flag & {N{~clr}}) | ev_done;
      end
   end

   // -------------------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------------------
   wire [2:0] rd_idx = rd_addr[4:2];
   wire [31:0] rd_sc1 = {21'h000000, a_trim, a_ss, a_topo, a_off, filt1,
                         pol1, a_lvl};
   wire [31:0] rd_cb = {26'h0000000, b_trim, b_ss, b_topo, b_lvl};
   wire [31:0] rd_sl = {23'h000000, full2, slot_lvl[3], slot_lvl[2],
                        slot_lvl[1], slot_lvl[0]};
   wire [31:0] rd_rs = {19'h00000, art_en, 3'h0, rst_ctrl};
   wire [31:0] rd_st = {8'h00, done_flag, fail_flag, tout_flag, ins_evt,
                        good, present2, present1};

   assign rd_word =
      hit(rd_addr, cpa_pkg::OFF_SC1) ? rd_sc1 :
      hit(rd_addr, cpa_pkg::OFF_CONVB) ? rd_cb :
      hit(rd_addr, cpa_pkg::OFF_SLOTS) ? rd_sl :
      hit(rd_addr, cpa_pkg::OFF_RST) ? rd_rs :
      hit(rd_addr, cpa_pkg::OFF_STATUS) ? rd_st :
      bank_hit(rd_addr, cpa_pkg::BANK_TIMER) ? {16'h0000, timer[rd_idx]} :
      bank_hit(rd_addr, cpa_pkg::BANK_CAPT) ? {16'h0000, capt[rd_idx]} :
      32'h00000000;

   // -------------------------------------------------------------------------
   // registered outputs
   // -------------------------------------------------------------------------
   // R18 direct or automatic reset
   wire [N-1:0] next_reset = (art_en & rel) | (~art_en & ctrl_eff);
   // R14 regulator 3 follows 2
   wire [7:0] next_sel = {slot_lvl[3], slot_lvl[2], lvl3, slot_lvl[0]};

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         conv_a_run_o <= 1'b0;
         conv_a_level_o <= 2'h0;
         conv_a_topology_sel_o <= 1'b0;
         conv_a_softstart_level_o <= 2'h0;
         conv_a_overcurrent_trim_o <= 1'b0;
         conv_b_run_o <= 1'b0;
         conv_b_level_o <= 2'h0;
         conv_b_topology_sel_o <= 1'b0;
         conv_b_softstart_level_o <= 2'h0;
         conv_b_overcurrent_trim_o <= 1'b0;
         slot_linear_reg_o <= 4'h0;
         slot_supply_sel_o <= 8'h00;
         card_reset_out_o <= 5'h00;
      end else begin
         conv_a_run_o <= a_run;
         conv_a_level_o <= a_lvl;
         // R7 topology select
         conv_a_topology_sel_o <= a_topo;
         conv_a_softstart_level_o <= a_ss;
         // R9 overcurrent trim
         conv_a_overcurrent_trim_o <= a_trim;
         conv_b_run_o <= running[1];
         conv_b_level_o <= b_lvl;
         conv_b_topology_sel_o <= b_topo;
         conv_b_softstart_level_o <= b_ss;
         conv_b_overcurrent_trim_o <= b_trim;
         // R12 regulator enables
         slot_linear_reg_o <= running[5:2];
         slot_supply_sel_o <= next_sel;
         card_reset_out_o <= next_reset;
      end
   end

endmodule : cpa_card_power_ctrl

`default_nettype wire

// ---- rtl/cpa_pkg.sv ----
// How it works
// [R1] Slot-1 presence level is inverted or not by the detect polarity bit.
// [R2] Slot-1 presence is debounced; the length comes from a 3-bit filter select.
// [R3] Any change of filtered slot-1 presence sets a sticky insertion event.
// [R4] Converter A start refused without presence; losing presence shuts it down.
// [R5] Nonzero slot-1 level starts converter A; good once output stays in range.
// [R6] Extraction, out-of-range or converter-off bit stop converter A automatically.
// [R7] Topology bit 0 selects inductor pump mode, 1 selects regulator mode.
// [R8] Software raises soft-start current only until good, then lowers it.
// [R9] Overcurrent trim bit shifts each converter's sensitivity by about 20 percent.
// [R10] Converter B starts whatever the slot-2 presence input shows.
// [R11] Nonzero converter B level starts it; good once output settles in range.
// [R12] With converter B good, a slot 2-5 level write starts its linear regulator; slot 2 also needs slot-2 presence.
// [R13] Software starts slot 2 first, then slots 3-5 one by one after good.
// [R14] Slot-2 full pinout disables slot 3 and copies slot-2 level to regulator 3.
// [R15] Activation needs presence on slots 1-2, converter B good on slots 3-5.
// [R16] Writing a slot's supply level starts that slot's activation sequence.
// [R17] Software read-clears a slot's status flags before activating it.
// [R18] Without auto reset timing, card reset follows the software control bit.
// [R19] Auto mode: 16-bit card-clock count, release at delay, clear, stop at answer.
// [R20] Card I/O is ignored for 200 card clocks after the counter starts.
// [R21] Answer before release fails: reset stays asserted, count is captured.
// [R22] Answer after release and before overflow completes, count is captured.
// [R23] Reset delay registers reset to 400 card clocks.
// [R24] No answer before counter overflow sets the slot's answer timeout flag.
// [R25] Answer start is the first card I/O falling edge sampled on card clock.
`default_nettype none

package cpa_pkg;

   localparam int NSLOT = 5;
   localparam int NSUP = 6;
   localparam int LVL_W = 2;
   localparam int CNT_W = 16;

   // ----------------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFF_SC1 = 8'h00;
   localparam logic [7:0] OFF_CONVB = 8'h04;
   localparam logic [7:0] OFF_SLOTS = 8'h08;
   localparam logic [7:0] OFF_RST = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [2:0] BANK_TIMER = 3'h1;
   localparam logic [2:0] BANK_CAPT = 3'h2;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int SC1_LVL = 0;
   localparam int SC1_POL = 2;
   localparam int SC1_FILT = 3;
   localparam int SC1_OFF = 6;
   localparam int SC1_TOPO = 7;
   localparam int SC1_SS = 8;
   localparam int SC1_TRIM = 10;
   localparam int CB_LVL = 0;
   localparam int CB_TOPO = 2;
   localparam int CB_SS = 3;
   localparam int CB_TRIM = 5;
   localparam int SL_FULL = 8;
   localparam int RST_CTRL = 0;
   localparam int RST_ART = 8;

   // ----------------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------------
   localparam logic [CNT_W-1:0] TIMER_RST = 16'h0190;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
   localparam logic [7:0] IGNORE_CYC = 8'hc8;
   localparam int FILT_SHIFT = 2;
   localparam int CLK_NS = 4;
   localparam int SETTLE_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [3:0] {
      ART_IDLE = 4'b0001,
      ART_WAIT = 4'b0010,
      ART_HELD = 4'b0100,
      ART_END = 4'b1000
   } cpa_art_e;

endpackage : cpa_pkg

`default_nettype wire

// ---- sim/cpa_card_model.sv ----
`default_nettype none
module cpa_card_model (
   input wire logic clock_i, // clock
   input wire logic early_i, // answer while held
   input wire logic oor_i, // spoil supply a
   input wire logic conv_a_run_i, // a on
   input wire logic conv_b_run_i, // b on
   input wire logic [3:0] slot_linear_reg_i, // regulators
   input wire logic [4:0] card_reset_i, // high = released
   output logic [5:0] supply_in_range_o, // comparators
   output logic [4:0] card_clk_o, // card clocks
   output wire logic [4:0] card_io_o // card i/o, pulled up
);
   // --------
   // cards
   // --------
   logic [1:0] div = 2'h0;
   logic [4:0] pw;
   int cnt [5] = '{default: 0};
   assign pw = {slot_linear_reg_i, conv_a_run_i};
   assign supply_in_range_o = {slot_linear_reg_i, conv_b_run_i,
      conv_a_run_i & ~oor_i};
   assign card_clk_o = {5{div[1]}};
   always @(posedge clock_i) div <= div + 2'h1;
   // early cards glitch inside the ignore span, then answer at 300
   for (genvar i = 0; i < 5; i++) begin : g_card
      always @(posedge div[1])
         cnt[i] <= (!pw[i] || (!early_i && !card_reset_i[i])) ? 0
            : cnt[i] + 1;
      assign card_io_o[i] = early_i ? (cnt[i] < 100 || cnt[i] > 101)
         && cnt[i] < 300 : cnt[i] < 50;
   end
endmodule // cpa_card_model
`default_nettype wire

// ---- sim/cpa_card_power_ctrl_tb.sv ----
`default_nettype none
module cpa_card_power_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwr = 1'b0;
   logic det1 = 1'b0, det2 = 1'b0, early = 1'b0, oor = 1'b0;
   logic [1:0] htr = 2'h0;
   logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, q;
   logic hro, hrs, a_run, a_t, a_tr, b_run, b_t, b_tr;
   logic [1:0] a_l, a_s, b_l, b_s;
   logic [3:0] ldo;
   logic [7:0] sel;
   logic [4:0] crst, cclk, cio;
   logic [5:0] rng;
   int err_total = 0, checks = 0, cyc = 0, n;
   cpa_card_power_ctrl #(.SETTLE(4)) cpa_card_power_ctrl_inst (
      .clock_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(ha),
      .htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwd),
      .hready_i(hro), .hrdata_o(hrd), .hreadyout_o(hro), .hresp_o(hrs),
      .card_detect_in_1_i(det1), .card_detect_in_2_i(det2),
      .supply_in_range_i(rng), .card_clk_i(cclk), .card_io_line_i(cio),
      .conv_a_run_o(a_run), .conv_a_level_o(a_l),
      .conv_a_topology_sel_o(a_t), .conv_a_softstart_level_o(a_s),
      .conv_a_overcurrent_trim_o(a_tr), .conv_b_run_o(b_run),
      .conv_b_level_o(b_l), .conv_b_topology_sel_o(b_t),
      .conv_b_softstart_level_o(b_s), .conv_b_overcurrent_trim_o(b_tr),
      .slot_linear_reg_o(ldo), .slot_supply_sel_o(sel),
      .card_reset_out_o(crst));
   cpa_card_model cpa_card_model_inst (.clock_i(clk), .early_i(early),
      .oor_i(oor), .conv_a_run_i(a_run), .conv_b_run_i(b_run),
      .slot_linear_reg_i(ldo), .card_reset_i(crst),
      .supply_in_range_o(rng), .card_clk_o(cclk), .card_io_o(cio));
   // --------
   // bus and checks
   // --------
   initial forever #2 clk = ~clk;
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic xf(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      htr <= 2'h2;
      hwr <= w;
      ha <= {24'h0, a};
      @(posedge clk);
      while (hro !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htr <= 2'h0;
      hwd <= d;
      @(posedge clk);
      while (hro !== 1'b1) @(posedge clk);
      q = hrd;
      wt(3);
   endtask
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // --------
   // scenarios
   // --------
   task automatic t_sc1();
      xf(1, 8'h00, 32'hc);
      wt(8);
      xf(1, 8'h00, 32'hd);
      chk(a_run, 0);
      xf(0, 8'h10, 0);
      det1 <= 1'b1;
      wt(2);
      det1 <= 1'b0;
      xf(0, 8'h10, 0);
      chk(q & 32'h101, 0);
      det1 <= 1'b1;
      wt(6);
      xf(0, 8'h10, 0);
      chk(q & 32'h101, 32'h101);
      xf(1, 8'h00, 32'h68d);
      chk(32'({a_run, a_l, a_t, a_s, a_tr}), 32'h5d);
      wt(8);
      xf(0, 8'h10, 0);
      chk(q & 32'h4, 32'h4);
      oor <= 1'b1;
      wt(3);
      chk(a_run, 0);
      $display("converter a test done");
   endtask
   task automatic t_b();
      xf(1, 8'h04, 32'h2);
      chk(32'({b_run, b_l, b_t, b_s, b_tr}), 32'h60);
      wt(8);
      xf(1, 8'h08, 32'h1);
      chk(32'(ldo), 0);
      det2 <= 1'b1;
      xf(1, 8'h08, 32'h1);
      chk(32'(ldo), 1);
      wt(8);
      xf(1, 8'h08, 32'h131);
      chk(32'(sel), 32'h35);
      xf(1, 8'h0c, 32'h10);
      chk(32'(crst), 32'h10);
      xf(1, 8'h0c, 0);
      $display("converter b test done");
   endtask
   task automatic t_art();
      xf(0, 8'h20, 0);
      chk(q, 32'h190);
      xf(0, 8'h80, 0);
      chk(q, 0);
      oor <= 1'b0;
      early <= 1'b1;
      xf(1, 8'h00, 32'h48d);
      xf(0, 8'h10, 0);
      xf(1, 8'h0c, 32'h101);
      wt(1800);
      chk(32'(crst), 0);
      xf(0, 8'h40, 0);
      chk(32'(q >= 200 && q < 400), 1);
      early <= 1'b0;
      xf(1, 8'h0c, 0);
      xf(1, 8'h0c, 32'h101);
      n = 3;
      while (crst[0] !== 1'b1) begin
         n++;
         wt(1);
      end
      chk(32'(n > 1590 && n < 1615), 1);
      wt(400);
      xf(0, 8'h10, 0);
      chk(q & 32'h84000, 32'h84000);
      xf(0, 8'h40, 0);
      chk(32'(q > 44 && q < 56), 1);
      det1 <= 1'b0;
      wt(8);
      chk(a_run, 0);
      $display("reset timing test done");
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop();
      end
   end
   initial begin
      wt(5);
      rst <= 1'b0;
      wt(2);
      t_sc1();
      t_b();
      t_art();
      report_and_stop();
   end
endmodule // cpa_card_power_ctrl_tb
bind cpa_card_power_ctrl cpa_chk #(.SETTLE(SETTLE)) cpa_chk_inst (.*);
`default_nettype wire

// ---- sim/cpa_chk.sv ----
`default_nettype none
module cpa_chk #(
   parameter int SETTLE = 4
) (
   input wire logic clock_i, // clock
   input wire logic rst_i, // reset
   input wire logic hreadyout_o, // ready
   input wire logic hresp_o, // response
   input wire logic [5:0] supply_in_range_i, // in range
   input wire logic conv_a_run_o, // a on
   input wire logic [1:0] conv_a_level_o, // a level
   input wire logic conv_b_run_o, // b on
   input wire logic [1:0] conv_b_level_o, // b level
   input wire logic [3:0] slot_linear_reg_o, // regulators
   input wire logic [7:0] slot_supply_sel_o, // slot levels
   input wire logic [4:0] card_reset_out_o // card resets
);
   // --------
   // checks
   // --------
   default clocking dc @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   // eight cycles outlast the settle count
   sequence s_a_good;
      (conv_a_run_o && supply_in_range_i[0]) [*8];
   endsequence
   sequence s_a_drop;
      !supply_in_range_i[0];
   endsequence
   a_bus_ready: assert property (!$past(rst_i) |-> hreadyout_o)
      else $error("bus not ready");
   a_bus_okay: assert property (!hresp_o)
      else $error("bus response not okay");
   a_a_run_lvl: assert property (
      conv_a_run_o == (conv_a_level_o != 2'h0)) else $error("a run bad");
   a_b_run_lvl: assert property (
      conv_b_run_o == (conv_b_level_o != 2'h0)) else $error("b run bad");
   a_ldo_lvl: assert property (
      slot_linear_reg_o[0] == (slot_supply_sel_o[1:0] != 2'h0))
      else $error("slot 2 regulator bad");
   a_ldo_need_b: assert property (
      $rose(|slot_linear_reg_o) |-> $past(conv_b_run_o))
      else $error("regulator without converter b");
   a_slot5_need_b: assert property (
      $rose(card_reset_out_o[4]) |-> conv_b_run_o)
      else $error("slot 5 reset without converter b");
   a_a_stop_range: assert property (
      s_a_good ##1 s_a_drop |-> ##[1:2] !conv_a_run_o)
      else $error("converter a runs out of range");
endmodule // cpa_chk
`default_nettype wire
